// file: bench/aic_engine_model.sv
/*
  Converter engine stand-in: while run is high it converts channels
  5, 6 and 7, then reports the group finished.
  Assumes the bench supplies the two guarded results.
*/
`timescale 1ns/1ps
`default_nettype none

module aic_engine_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] res6,
  input  wire logic [7:0] res7,
  output logic            valid,
  output logic      [2:0] chan,
  output logic      [7:0] data,
  output logic            done
);
  logic [2:0] step;
  logic [2:0] next_step;

  // Dropping run abandons the group with no done pulse
  always_comb begin
    next_step = 3'h0;
    if (run && step != 3'h4) begin
      next_step = step + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step <= 3'h0;
    end else begin
      step <= next_step;
    end
  end

  // Data outside channels 6 and 7 is scrambled from res6 so a stale result is never seen
  assign valid = step inside {3'h1, 3'h2, 3'h3};
  assign chan  = valid ? step + 3'h4 : {step[1:0], 1'b0};
  assign data  = step == 3'h2 ? res6 : step == 3'h3 ? res7 : ~res6 ^ {5'h0, step};
  assign done  = step == 3'h4;
endmodule

`default_nettype wire

// file: bench/tb_top.sv
/*
  Self-checking bench for the converter interrupt and start control.
  Assumes the engine stand-in beside it and one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import aic_pkg::*;
;
  logic       mclk      = 1'b0;
  logic       rst_n     = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       trig_ext  = 1'b0;
  logic       trig_int  = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] res6      = 8'h00;
  logic [7:0] res7      = 8'h00;
  logic [7:0] reg_rdata;
  logic       conv_result_valid;
  logic [2:0] conv_channel;
  logic [7:0] conv_result;
  logic       group_done;
  logic       run_group;
  logic       repeat_mode;
  logic       conv_abort;
  logic       adc_irq_req;
  logic [2:0] adc_irq_level;
  logic [7:0] adc_irq_vector;
  logic       irq;
  logic [31:0] seed = 32'ha798;
  logic [7:0] m_thr [4];
  logic [7:0] m_ic;
  logic [3:0] m_hit = 4'h0;
  logic [2:0] m_st  = 3'h0;
  logic       m_ws  = 1'b1;
  int         n_fail, tests_run, cyc, n_grp, g;

  always #2 mclk = ~mclk;

  aic_ctrl aic_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_result_valid(conv_result_valid), .conv_channel(conv_channel),
    .conv_result(conv_result), .group_done(group_done), .trig_ext(trig_ext),
    .trig_int(trig_int), .run_group(run_group), .repeat_mode(repeat_mode),
    .conv_abort(conv_abort), .adc_irq_req(adc_irq_req), .adc_irq_level(adc_irq_level),
    .adc_irq_vector(adc_irq_vector), .irq(irq));

  aic_engine_model aic_engine_model_inst (.mclk(mclk), .rst_n(rst_n), .run(run_group),
    .res6(res6), .res7(res7), .valid(conv_result_valid), .chan(conv_channel),
    .data(conv_result), .done(group_done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Abort shows in the write cycle of control writes only; the closing
  // delay lets callers look at registers once the write has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    #1;
    chk("abort", conv_abort, {7'h00, a == AIC_OFS_CTRL});
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic pulse(input logic ext);
    @(posedge mclk);
    trig_ext <= ext;
    trig_int <= !ext;
    @(posedge mclk);
    trig_ext <= 1'b0;
    trig_int <= 1'b0;
  endtask

  // Bounded wait for the run bit to fall, then fold the group into the model
  task automatic group_run();
    logic [3:0] h;
    #1;
    for (int i = 0; i < 40 && run_group !== 1'b0; i++) @(posedge mclk);
    #1;
    h = {res7 >= m_thr[3], res6 >= m_thr[2], res7 < m_thr[1], res6 < m_thr[0]};
    m_hit = m_hit | h;
    m_ic[7] = 1'b1;
    m_ic[6] = m_ic[6] | (h != 4'h0);
    m_st = m_st | {1'b0, h != 4'h0, 1'b1};
    if (m_ic[6] & m_ic[4]) begin
      m_ws = 1'b0;
    end else if (m_ic[5]) begin
      m_ws = 1'b1;
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard and group counter
  always @(posedge mclk) begin
    cyc++;
    if (group_done === 1'b1) n_grp++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("level", adc_irq_level, 8'h07);
    chk("vector", adc_irq_vector, 8'h02);
    rd(AIC_OFS_IRQ_CTRL, 8'h0f, "irq_ctrl");
    rd(AIC_OFS_HIT, 8'h0f, "hits");
    rd(AIC_OFS_CTRL, 8'h00, "ctrl");
    rd(8'h10, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      m_thr[i] = seed[7:0];
      wr(8'hf8 + i[7:0], seed[7:0]);
      rd(8'hf8 + i[7:0], m_thr[i], "threshold");
    end
    seed = lfsr(seed);
    wr(AIC_OFS_VECTOR, seed[7:0]);
    rd(AIC_OFS_VECTOR, {seed[7:2], 2'b10}, "vector");
    m_ic = {5'h01, seed[10:8]};
    wr(AIC_OFS_IRQ_CTRL, m_ic);
    chk("level", adc_irq_level, m_ic[2:0]);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00, "unmapped");
    $display("test registers done");
    // Each enable pairing once; odd passes sit exactly on the upper limit
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      res6 <= k[0] ? m_thr[2] : seed[7:0];
      res7 <= (k == 2) ? m_thr[1] : seed[15:8];
      m_ic[5:4] = k[1:0];
      wr(AIC_OFS_IRQ_CTRL, m_ic);
      wr(AIC_OFS_EVT_MASK, {6'h00, k[1:0]});
      wr(AIC_OFS_CTRL, 8'h01);
      group_run();
      rd(AIC_OFS_IRQ_CTRL, m_ic, "irq_ctrl");
      rd(AIC_OFS_HIT, {m_hit, 4'hf}, "hits");
      rd(AIC_OFS_EVT_STAT, {5'h00, m_st}, "status");
      chk("req", adc_irq_req, (m_ic[7] & m_ic[5]) | (m_ic[6] & m_ic[4]));
      chk("word_select", adc_irq_vector[1], m_ws);
      chk("irq", irq, |(m_st[1:0] & k[1:0]));
      chk("run", run_group, 8'h00);
      chk("groups", n_grp[7:0], k[7:0] + 8'h01);
      if (k == 3) begin
        m_ic[6] = 1'b0;
        wr(AIC_OFS_IRQ_CTRL, m_ic);
        rd(AIC_OFS_IRQ_CTRL, m_ic, "irq_ctrl");
        chk("pending_done", adc_irq_vector[1], 8'h01);
      end
      m_ic[7:6] = 2'b00;
      wr(AIC_OFS_IRQ_CTRL, m_ic);
      rd(AIC_OFS_HIT, 8'h0f, "hits_cleared");
      m_hit = 4'h0;
      wr(AIC_OFS_EVT_STAT, 8'h07);
      m_st = 3'h0;
      #1;
      chk("irq_clear", irq, 8'h00);
      $display("test group %0d done", k);
    end
    // Software sets the done flag itself
    m_ic = {8'ha8 | {5'h00, m_ic[2:0]}};
    wr(AIC_OFS_IRQ_CTRL, m_ic);
    rd(AIC_OFS_IRQ_CTRL, m_ic, "irq_ctrl");
    rd(AIC_OFS_EVT_STAT, 8'h04, "status");
    chk("req", adc_irq_req, 8'h01);
    chk("word_select", adc_irq_vector[1], 8'h01);
    $display("test software request done");
    g = n_grp;
    wr(AIC_OFS_CTRL, 8'h01);
    wr(AIC_OFS_CTRL, 8'h00);
    repeat (8) @(posedge mclk);
    #1;
    chk("stopped", run_group, 8'h00);
    chk("no_group", n_grp[7:0], g[7:0]);
    $display("test abort done");
    // Only the enabled trigger source may launch one group
    wr(AIC_OFS_CTRL, 8'h08);
    pulse(1'b1);
    #1;
    chk("ext_off", run_group, 8'h00);
    pulse(1'b0);
    group_run();
    chk("int_group", n_grp[7:0], g[7:0] + 8'h01);
    wr(AIC_OFS_CTRL, 8'h10);
    pulse(1'b1);
    group_run();
    chk("ext_group", n_grp[7:0], g[7:0] + 8'h02);
    wr(AIC_OFS_CTRL, 8'h03);
    repeat (12) @(posedge mclk);
    #1;
    chk("repeat", {run_group, repeat_mode}, 8'h03);
    chk("repeat_groups", n_grp[7:0] >= g[7:0] + 8'h04, 8'h01);
    wr(AIC_OFS_CTRL, 8'h00);
    $display("test triggers done");
    print_verdict();
  end
endmodule

`default_nettype wire

// file: verilog/aic_ctrl.sv
/*
  Interrupt and start/stop control of an 8-channel converter: run bit,
  done and range flags, threshold hits, priority, vector and word select.
  Assumes a converter engine that reports each result and each finished
  group as one-cycle pulses, and a register master that never waits.
*/
// The plain strobed port was chosen for this implementation.
// How it works
// - Run bit written 1 allows a group to start, written 0 stops it.
// - In single mode hardware clears the run bit when a group ends.
// - Group completion sets the done flag in interrupt control bit 7.
// - A guarded result outside its window sets the range flag, bit 6.
// - Channel 6 compares against the limits at F8h and FAh.
// - Channel 7 compares against the limits at F9h and FBh.
// - Software writing 1 to either flag raises a software request.
// - Done enable in bit 5 passes or masks the done request.
// - Range enable in bit 4 passes or masks the range request.
// - Bits 2 to 0 give the priority level shown with requests.
// - Word select reads 0 for the range source, 1 for done.
// - Range is served first; done stays pending meanwhile.
// - Vector bit 0 always reads as zero.
// - Software clearing a flag forces all threshold hit bits to zero.
// - Upper hit bit sets when result is at or above the upper limit.
// - Single mode launches exactly one group per start or trigger.
`timescale 1ns/1ps
`default_nettype none

module aic_ctrl
  import aic_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       conv_result_valid,
  input  wire logic [2:0] conv_channel,
  input  wire logic [7:0] conv_result,
  input  wire logic       group_done,
  input  wire logic       trig_ext,
  input  wire logic       trig_int,
  output logic            run_group,
  output logic            repeat_mode,
  output logic            conv_abort,
  output logic            adc_irq_req,
  output logic      [2:0] adc_irq_level,
  output logic      [7:0] adc_irq_vector,
  output logic            irq
);

  // Register state
  logic [7:0] lower_lim [0:1];
  logic [7:0] upper_lim [0:1];
  logic [3:0] threshold_hit_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] adc_irq_control_reg;
  logic [5:0] vector_base;
  logic       word_select;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;

  logic [7:0] next_lower_lim [0:1];
  logic [7:0] next_upper_lim [0:1];
  logic [3:0] next_threshold_hit_reg;
  logic [7:0] next_ctrl_reg;
  logic [7:0] next_adc_irq_control_reg;
  logic [5:0] next_vector_base;
  logic       next_word_select;
  logic [2:0] next_evt_status;
  logic [2:0] next_evt_mask;
  logic [7:0] next_reg_rdata;

  logic       guard_valid;
  logic       guard_sel;
  logic       hit_upper;
  logic       hit_lower;
  logic       out_of_range;
  logic       done_req;
  logic       range_req;
  logic       wr_icr;
  logic       flag_cleared;
  logic       sw_request;
  logic       hw_trigger;
  logic [8:0] wr_key;

  // Write decode, used for every register; strobe and address travel as an
  // argument so that continuous assignments re-evaluate when they change
  function automatic logic wr_hit(input logic [8:0] key, input logic [7:0] ofs);
    wr_hit = key[8] && (key[7:0] == ofs);
  endfunction

  // One comparator is shared, since only one result arrives per cycle
  assign guard_valid = conv_result_valid && (conv_channel[2:1] == AIC_GUARD_CH_HI);
  assign guard_sel   = conv_channel[0];

  aic_guard_cmp u_guard (
    .data      (conv_result),
    .lower     (lower_lim[guard_sel]),
    .upper     (upper_lim[guard_sel]),
    .hit_upper (hit_upper),
    .hit_lower (hit_lower)
  );

  assign out_of_range = guard_valid && (hit_upper || hit_lower);

  // Gated requests toward the core
  assign done_req  = adc_irq_control_reg[AIC_IC_EOC] &&
                     adc_irq_control_reg[AIC_IC_DONE_EN];
  assign range_req = adc_irq_control_reg[AIC_IC_RANGE] &&
                     adc_irq_control_reg[AIC_IC_RANGE_EN];

  assign wr_key       = {reg_wr, reg_addr};
  assign wr_icr       = wr_hit(wr_key, AIC_OFS_IRQ_CTRL);
  assign flag_cleared = wr_icr &&
    ((adc_irq_control_reg[AIC_IC_EOC] && !reg_wdata[AIC_IC_EOC]) ||
     (adc_irq_control_reg[AIC_IC_RANGE] && !reg_wdata[AIC_IC_RANGE]));
  assign sw_request   = wr_icr && (reg_wdata[AIC_IC_EOC] || reg_wdata[AIC_IC_RANGE]);
  assign hw_trigger   = (trig_ext && ctrl_reg[AIC_CTRL_EXTTRG]) ||
                        (trig_int && ctrl_reg[AIC_CTRL_INTTRG]);

  // Next values of all software-visible state
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_lower_lim[i] = lower_lim[i];
      next_upper_lim[i] = upper_lim[i];
    end
    if (wr_hit(wr_key, AIC_OFS_LT6)) next_lower_lim[0] = reg_wdata;
    if (wr_hit(wr_key, AIC_OFS_LT7)) next_lower_lim[1] = reg_wdata;
    if (wr_hit(wr_key, AIC_OFS_UT6)) next_upper_lim[0] = reg_wdata;
    if (wr_hit(wr_key, AIC_OFS_UT7)) next_upper_lim[1] = reg_wdata;

    // Run bit: a register write is a fresh command and beats the engine
    next_ctrl_reg = ctrl_reg;
    if (hw_trigger) begin
      next_ctrl_reg[AIC_CTRL_RUN] = 1'b1;
    end else if (group_done && !ctrl_reg[AIC_CTRL_REPEAT]) begin
      next_ctrl_reg[AIC_CTRL_RUN] = 1'b0;
    end
    if (wr_hit(wr_key, AIC_OFS_CTRL)) next_ctrl_reg = reg_wdata;

    // Threshold hits: software loads them, hardware only sets; the forced clear must win
    next_threshold_hit_reg = threshold_hit_reg;
    if (wr_hit(wr_key, AIC_OFS_HIT)) next_threshold_hit_reg = reg_wdata[7:4];
    if (guard_valid && hit_upper) begin
      next_threshold_hit_reg[guard_sel ? AIC_HIT_C7U : AIC_HIT_C6U] = 1'b1;
    end
    if (guard_valid && hit_lower) begin
      next_threshold_hit_reg[guard_sel ? AIC_HIT_C7L : AIC_HIT_C6L] = 1'b1;
    end
    if (flag_cleared) next_threshold_hit_reg = AIC_RST_HIT;

    // Flags: hardware set beats a software clear in the same cycle
    next_adc_irq_control_reg = adc_irq_control_reg;
    if (wr_icr) begin
      next_adc_irq_control_reg = reg_wdata;
      next_adc_irq_control_reg[AIC_IC_SPARE] = 1'b1;
    end
    if (group_done) next_adc_irq_control_reg[AIC_IC_EOC] = 1'b1;
    if (out_of_range) next_adc_irq_control_reg[AIC_IC_RANGE] = 1'b1;

    // Vector base from software, word select from the served source
    next_vector_base = vector_base;
    if (wr_hit(wr_key, AIC_OFS_VECTOR)) next_vector_base = reg_wdata[7:2];
    if (range_req) begin
      next_word_select = 1'b0;
    end else if (done_req) begin
      next_word_select = 1'b1;
    end else begin
      next_word_select = word_select;
    end

    // Sticky events: write one to clear, a new event wins
    next_evt_status = evt_status;
    if (wr_hit(wr_key, AIC_OFS_EVT_STAT)) next_evt_status = evt_status & ~reg_wdata[2:0];
    if (group_done) next_evt_status[AIC_EVT_DONE] = 1'b1;
    if (out_of_range) next_evt_status[AIC_EVT_RANGE] = 1'b1;
    if (sw_request) next_evt_status[AIC_EVT_SWI] = 1'b1;
    next_evt_mask = evt_mask;
    if (wr_hit(wr_key, AIC_OFS_EVT_MASK)) next_evt_mask = reg_wdata[2:0];

    // Read data, valid only in the cycle after the strobe
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        AIC_OFS_LT6:      next_reg_rdata = lower_lim[0];
        AIC_OFS_LT7:      next_reg_rdata = lower_lim[1];
        AIC_OFS_UT6:      next_reg_rdata = upper_lim[0];
        AIC_OFS_UT7:      next_reg_rdata = upper_lim[1];
        AIC_OFS_HIT:      next_reg_rdata = {threshold_hit_reg, AIC_HIT_LOW_ONES};
        AIC_OFS_CTRL:     next_reg_rdata = ctrl_reg;
        AIC_OFS_IRQ_CTRL: next_reg_rdata = adc_irq_control_reg;
        AIC_OFS_VECTOR:   next_reg_rdata = {vector_base, word_select, 1'b0};
        AIC_OFS_EVT_STAT: next_reg_rdata = {5'h00, evt_status};
        AIC_OFS_EVT_MASK: next_reg_rdata = {5'h00, evt_mask};
        default:          next_reg_rdata = 8'h00;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        lower_lim[i] <= AIC_RST_THRESH;
        upper_lim[i] <= AIC_RST_THRESH;
      end
      threshold_hit_reg   <= AIC_RST_HIT;
      ctrl_reg            <= AIC_RST_CTRL;
      adc_irq_control_reg <= AIC_RST_IRQ_CTRL;
      vector_base         <= AIC_RST_VEC_BASE;
      word_select         <= AIC_RST_WS;
      evt_status          <= AIC_RST_EVT;
      evt_mask            <= AIC_RST_EVT;
      reg_rdata           <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        lower_lim[i] <= next_lower_lim[i];
        upper_lim[i] <= next_upper_lim[i];
      end
      threshold_hit_reg   <= next_threshold_hit_reg;
      ctrl_reg            <= next_ctrl_reg;
      adc_irq_control_reg <= next_adc_irq_control_reg;
      vector_base         <= next_vector_base;
      word_select         <= next_word_select;
      evt_status          <= next_evt_status;
      evt_mask            <= next_evt_mask;
      reg_rdata           <= next_reg_rdata;
    end
  end

  // Outputs; the abort pulse lets the engine restart on any control write
  assign run_group      = ctrl_reg[AIC_CTRL_RUN];
  assign repeat_mode    = ctrl_reg[AIC_CTRL_REPEAT];
  assign conv_abort     = wr_hit(wr_key, AIC_OFS_CTRL);
  assign adc_irq_req    = done_req || range_req;
  assign adc_irq_level  = adc_irq_control_reg[2:0];
  assign adc_irq_vector = {vector_base, word_select, 1'b0};
  assign irq            = |(evt_status & evt_mask);

  // Checks
  sequence s_single_end;
    group_done && run_group && !repeat_mode && !reg_wr && !hw_trigger;
  endsequence

  property p_single_stop;
    @(posedge mclk) disable iff (!rst_n) s_single_end |=> !run_group;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("run bit kept after group");

  property p_run_write;
    @(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == AIC_OFS_CTRL |=> run_group == $past(reg_wdata[0]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit not written");

  property p_done_flag;
    @(posedge mclk) disable iff (!rst_n)
      group_done |=> adc_irq_control_reg[AIC_IC_EOC] && evt_status[AIC_EVT_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag missed");

  property p_range6;
    @(posedge mclk) disable iff (!rst_n)
      conv_result_valid && conv_channel == 3'h6 &&
      (conv_result >= upper_lim[0] || conv_result < lower_lim[0])
      |=> adc_irq_control_reg[AIC_IC_RANGE];
  endproperty
  a_range6: assert property (p_range6) else $error("ch6 range flag missed");

  property p_upper7;
    @(posedge mclk) disable iff (!rst_n)
      conv_result_valid && conv_channel == 3'h7 && conv_result >= upper_lim[1] &&
      !flag_cleared && !reg_wr |=> threshold_hit_reg[AIC_HIT_C7U];
  endproperty
  a_upper7: assert property (p_upper7) else $error("ch7 upper hit missed");

  property p_sw_request;
    @(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == AIC_OFS_IRQ_CTRL && reg_wdata[7] |=>
      evt_status[AIC_EVT_SWI] && adc_irq_control_reg[AIC_IC_EOC];
  endproperty
  a_sw_request: assert property (p_sw_request) else $error("software request lost");

  property p_request_gate;
    @(posedge mclk) disable iff (!rst_n)
      adc_irq_req == ((adc_irq_control_reg[7] && adc_irq_control_reg[5]) ||
                      (adc_irq_control_reg[6] && adc_irq_control_reg[4]));
  endproperty
  a_request_gate: assert property (p_request_gate) else $error("request gating wrong");

  property p_range_first;
    @(posedge mclk) disable iff (!rst_n)
      range_req && done_req |=> !word_select ##0 adc_irq_vector[0] == 1'b0;
  endproperty
  a_range_first: assert property (p_range_first) else $error("range not served first");

  property p_ws_done;
    @(posedge mclk) disable iff (!rst_n) done_req && !range_req |=> word_select;
  endproperty
  a_ws_done: assert property (p_ws_done) else $error("word select not one");

  property p_hit_clear;
    @(posedge mclk) disable iff (!rst_n) flag_cleared |=> threshold_hit_reg == 4'h0;
  endproperty
  a_hit_clear: assert property (p_hit_clear) else $error("hit bits not cleared");

  property p_vec_zero;
    @(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == AIC_OFS_VECTOR |=> reg_rdata[0] == 1'b0;
  endproperty
  a_vec_zero: assert property (p_vec_zero) else $error("vector bit 0 not zero");

  property p_level;
    @(posedge mclk) disable iff (!rst_n)
      wr_icr |=> adc_irq_level == $past(reg_wdata[2:0]);
  endproperty
  a_level: assert property (p_level) else $error("priority level wrong");

endmodule

`default_nettype wire

// file: verilog/aic_guard_cmp.sv
/*
  Window comparator for one guarded channel result.
  Assumes limits and data are plain unsigned 8-bit codes.
*/
`timescale 1ns/1ps
`default_nettype none

module aic_guard_cmp (
  input  wire logic [7:0] data,
  input  wire logic [7:0] lower,
  input  wire logic [7:0] upper,
  output logic            hit_upper,
  output logic            hit_lower
);

  // At or above the upper limit counts as a hit; below the lower one too
  always_comb begin
    hit_upper = (data >= upper);
    hit_lower = (data < lower);
  end

endmodule

`default_nettype wire

// file: verilog/aic_pkg.sv
/*
  Constants shared by the converter interrupt and start control block:
  register offsets, field positions, reset values and guard channels.
  Assumes an 8-bit register space and 8-bit register data.
*/
`default_nettype none

package aic_pkg;

  // Register offsets in the converter register page
  localparam logic [7:0] AIC_OFS_LT6      = 8'hf8;
  localparam logic [7:0] AIC_OFS_LT7      = 8'hf9;
  localparam logic [7:0] AIC_OFS_UT6      = 8'hfa;
  localparam logic [7:0] AIC_OFS_UT7      = 8'hfb;
  localparam logic [7:0] AIC_OFS_HIT      = 8'hfc;
  localparam logic [7:0] AIC_OFS_CTRL     = 8'hfd;
  localparam logic [7:0] AIC_OFS_IRQ_CTRL = 8'hfe;
  localparam logic [7:0] AIC_OFS_VECTOR   = 8'hff;
  localparam logic [7:0] AIC_OFS_EVT_STAT = 8'hec;
  localparam logic [7:0] AIC_OFS_EVT_MASK = 8'hed;

  // Control register fields
  localparam int AIC_CTRL_RUN    = 0;
  localparam int AIC_CTRL_REPEAT = 1;
  localparam int AIC_CTRL_INTTRG = 3;
  localparam int AIC_CTRL_EXTTRG = 4;

  // Interrupt control register fields
  localparam int AIC_IC_EOC      = 7;
  localparam int AIC_IC_RANGE    = 6;
  localparam int AIC_IC_DONE_EN  = 5;
  localparam int AIC_IC_RANGE_EN = 4;
  localparam int AIC_IC_SPARE    = 3;

  // Vector register fields
  localparam int AIC_VEC_WS = 1;

  // Threshold hit register: upper nibble holds the four hit bits
  localparam int AIC_HIT_C7U = 3;
  localparam int AIC_HIT_C6U = 2;
  localparam int AIC_HIT_C7L = 1;
  localparam int AIC_HIT_C6L = 0;

  // Event status and mask bits
  localparam int AIC_EVT_DONE  = 0;
  localparam int AIC_EVT_RANGE = 1;
  localparam int AIC_EVT_SWI   = 2;

  // Reset values
  localparam logic [7:0] AIC_RST_IRQ_CTRL = 8'h0f;
  localparam logic [7:0] AIC_RST_CTRL     = 8'h00;
  localparam logic [5:0] AIC_RST_VEC_BASE = 6'h00;
  localparam logic       AIC_RST_WS       = 1'b1;
  localparam logic [3:0] AIC_RST_HIT      = 4'h0;
  localparam logic [3:0] AIC_HIT_LOW_ONES = 4'hf;
  localparam logic [7:0] AIC_RST_THRESH   = 8'h00;
  localparam logic [2:0] AIC_RST_EVT      = 3'h0;

  // Guarded channels share the upper two channel bits
  localparam logic [1:0] AIC_GUARD_CH_HI = 2'h3;

endpackage

`default_nettype wire
